// ==== design/tape_codec_defs.svh ====
/*
 * Constants for the nine-track phase-encoded tape codec: track count,
 * bit-cell timing, burst lengths, gap length and clock-recovery limits.
 * Assumes a 100 MHz system clock and one bit cell of CELL_LAST+1 clocks.
 */
`ifndef TAPE_CODEC_DEFS_SVH
`define TAPE_CODEC_DEFS_SVH

`define NTRK           9
`define NSLOT          4
`define RING_N         8
`define CELL_LAST      4'hf
`define CELL_HALF      4'h8
`define BURST_N        6'h28
`define BURST_SKIP     6'h29
`define MARK_SYM       9'h1ff
`define ZERO_SYM       9'h000
`define GAP_TENTHS     8'h06
`define TACH_PER_TENTH 8'h0a
`define GAP_TACH       (`GAP_TENTHS * `TACH_PER_TENTH)
`define HALF_MIN       8'h03
`define JITTER_TOL     8'h02
`define LOCK_N         3'h4
`define CNT_MAX        8'hff

`endif

// ==== design/tape_codec_pkg.sv ====
/*
 * Types shared by the tape codec: state enumerations and the nine-bit
 * tape symbol (eight data tracks plus the parity track in bit 8).
 * Assumes nothing of its surroundings.
 */
package tape_codec_pkg;
   typedef logic [8:0] sym_t;
   typedef enum logic [2:0] {W_IDLE, W_GAP, W_PRE, W_DATA, W_POST} wr_state_t;
   typedef enum logic       {R_HUNT, R_DATA} rd_state_t;
   typedef enum logic [1:0] {T_HUNT, T_LOCK, T_DEAD} trk_state_t;
endpackage : tape_codec_pkg

// ==== design/track_bus_if.sv ====
/*
 * Carrier between the per-track clock recovery units and the deskew core.
 * Each recovery unit drives the bit of every vector at its own index.
 */
`timescale 1ns/1ps
`default_nettype none
interface track_bus_if;
   logic [8:0] bit_valid;
   logic [8:0] bit_val;
   logic [8:0] drop;
   logic [8:0] locked;
   logic       rearm;
   modport rx   (output bit_valid, output bit_val, output drop, output locked, input rearm);
   modport core (input bit_valid, input bit_val, input drop, input locked, output rearm);
endinterface : track_bus_if
`default_nettype wire

// ==== design/track_rx.sv ====
/*
 * One track's read clock recovery: learns the half-cell period from the
 * burst, then samples the direction of each mid-cell flux reversal.
 * Assumes head_in is an asynchronous head signal; rearm from the core.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tape_codec_defs.svh"
module track_rx #(
   parameter int IDX = 0
) (
   input  wire logic  clk,
   input  wire logic  rst_n,
   input  wire logic  head_in,
   track_bus_if.rx    tb
);
   import tape_codec_pkg::*;

   logic       s1_q, s2_q, lvl_q;
   logic [7:0] cnt_q, last_q, half_q;
   logic [2:0] match_q;
   trk_state_t st_q;

   wire       edge_w  = s2_q ^ lvl_q;
   wire       rise_w  = s2_q & ~lvl_q;
   wire [7:0] diff_w  = (cnt_q > last_q) ? (cnt_q - last_q) : (last_q - cnt_q);
   wire       near_w  = (diff_w <= `JITTER_TOL) && (cnt_q >= `HALF_MIN);
   wire [7:0] blank_w = half_q + (half_q >> 1);
   wire [7:0] limit_w = (half_q << 1) + (half_q >> 1);
   wire       hunt_w  = (st_q == T_HUNT);
   // steady burst spacing plus a falling (zero) mid edge gives lock
   wire       lock_w  = hunt_w && edge_w && !rise_w && near_w && (match_q == `LOCK_N);
   wire       mid_w   = (st_q == T_LOCK) && edge_w && (cnt_q >= blank_w);
   wire       lost_w  = (st_q == T_LOCK) && (cnt_q > limit_w);

   assign tb.bit_valid[IDX] = mid_w;
   assign tb.bit_val[IDX]   = rise_w;
   assign tb.drop[IDX]      = lost_w;
   assign tb.locked[IDX]    = (st_q == T_LOCK);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         lvl_q <= 1'b0;
      end else begin
         s1_q <= head_in;
         s2_q <= s1_q;
         lvl_q <= s2_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         last_q <= '0;
         match_q <= '0;
      end else begin
         if ((hunt_w && edge_w) || mid_w) cnt_q <= '0;
         else if (cnt_q != `CNT_MAX) cnt_q <= cnt_q + 8'h01;
         if (hunt_w && edge_w) begin
            last_q <= cnt_q;
            if (!near_w) match_q <= '0;
            else if (match_q != `LOCK_N) match_q <= match_q + 3'h1;
         end
      end
   end

   // a lost track stays dead until the core rearms it between blocks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= T_HUNT;
         half_q <= '0;
      end else begin
         case (st_q)
            T_HUNT: if (lock_w) begin
               st_q <= T_LOCK;
               half_q <= cnt_q;
            end
            T_LOCK: if (lost_w) st_q <= T_DEAD;
            T_DEAD: if (tb.rearm) st_q <= T_HUNT;
            default: st_q <= T_HUNT;
         endcase
      end
   end

   a_lock_after_burst: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(st_q == T_LOCK) |-> $past(match_q) == `LOCK_N)
      else $error("track locked without a steady burst");
endmodule : track_rx
`default_nettype wire

// ==== design/phase_encoded_tape_codec.sv ====
/*
 * Nine-track tape record/read codec: phase-encoded or transition-on-one
 * writing with gap timing, bursts in phase-encoded mode, per-track read clocking, deskew,
 * parity regeneration of a dropped track and readback checking.
 * Assumes head_rd and tach_pin are asynchronous; user side is on clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tape_codec_defs.svh"
module phase_encoded_tape_codec (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 phase_encoded_mode,
   input  wire logic                 wr_start,
   input  wire logic                 wr_valid,
   input  wire logic [7:0]           wr_data,
   input  wire logic                 wr_last,
   output logic                      wr_ready,
   input  wire logic                 tach_pin,
   input  wire tape_codec_pkg::sym_t head_rd,
   output tape_codec_pkg::sym_t      head_wr,
   output logic                      write_gate,
   output logic                      erase_on,
   output logic                      interblock_gap,
   output logic                      rd_valid,
   output logic [7:0]                rd_byte,
   output logic                      rd_fixed,
   output logic                      rd_sig_err,
   output logic                      rd_uncorr,
   output logic                      rd_block_end,
   output logic                      chk_err
);
   import tape_codec_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // write path
   wr_state_t  wst_q, wst_d;
   logic       mode_q, last_q, last_d;
   logic [3:0] cell_q;
   logic [5:0] bcnt_q, bcnt_d;
   sym_t       sym_q, sym_d, lvl_q, lvl_d, data_sym_w, mark_w;
   logic [7:0] gap_cnt_q;
   logic       t1_q, t2_q, t3_q;

   wire tach_w     = t2_q & ~t3_q;
   wire act_w      = (wst_q == W_PRE) || (wst_q == W_DATA) || (wst_q == W_POST);
   wire cell_end_w = act_w && (cell_q == `CELL_LAST);
   wire gap_done_w = (wst_q == W_GAP) && (gap_cnt_q == `GAP_TACH);
   wire in_data_w  = (wst_q == W_DATA) || ((wst_q == W_PRE) && (bcnt_q > `BURST_N));
   wire start_w    = (wst_q == W_IDLE) && wr_start;
   wire take_w     = wr_ready && wr_valid;

   assign wr_ready       = in_data_w && cell_end_w && !last_q;
   assign data_sym_w     = {~^wr_data, wr_data};
   // no check character: in phase-encoded mode the block closes straight into the trailing burst
   assign mark_w         = mode_q ? `MARK_SYM : `ZERO_SYM;
   assign head_wr        = lvl_q;
   assign write_gate     = act_w;
   assign erase_on       = (wst_q != W_IDLE);
   assign interblock_gap = (wst_q == W_GAP);

   always_comb begin
      wst_d = wst_q;
      sym_d = sym_q;
      bcnt_d = bcnt_q;
      last_d = last_q;
      case (wst_q)
         W_IDLE: if (wr_start) wst_d = W_GAP;
         W_GAP: if (gap_done_w) begin
            wst_d = W_PRE;
            sym_d = `ZERO_SYM;
            last_d = 1'b0;
            bcnt_d = mode_q ? 6'h01 : `BURST_SKIP;
         end
         W_PRE: if (cell_end_w) begin
            if (bcnt_q < `BURST_N) begin
               sym_d = `ZERO_SYM;
               bcnt_d = bcnt_q + 6'h01;
            end else if (bcnt_q == `BURST_N) begin
               sym_d = `MARK_SYM;
               bcnt_d = bcnt_q + 6'h01;
            end else if (take_w) begin
               wst_d = W_DATA;
               sym_d = data_sym_w;
               last_d = wr_last;
            end else begin
               wst_d = W_POST;
               sym_d = mark_w;
               bcnt_d = '0;
            end
         end
         W_DATA: if (cell_end_w) begin
            if (take_w) begin
               sym_d = data_sym_w;
               last_d = wr_last;
            end else begin
               wst_d = W_POST;
               sym_d = mark_w;
               bcnt_d = '0;
            end
         end
         W_POST: if (cell_end_w) begin
            if (mode_q && (bcnt_q < `BURST_N)) begin
               sym_d = `ZERO_SYM;
               bcnt_d = bcnt_q + 6'h01;
            end else begin
               wst_d = W_IDLE;
            end
         end
         default: wst_d = W_IDLE;
      endcase
   end

   // phase: cell start takes ~sym, mid-cell takes sym; nrzi: toggle on one
   always_comb begin
      lvl_d = lvl_q;
      if (act_w && (cell_q == '0)) lvl_d = mode_q ? ~sym_q : (lvl_q ^ sym_q);
      else if (act_w && mode_q && (cell_q == `CELL_HALF)) lvl_d = sym_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wst_q <= W_IDLE;
         sym_q <= '0;
         bcnt_q <= '0;
         last_q <= 1'b0;
         lvl_q <= '0;
         cell_q <= '0;
      end else begin
         wst_q <= wst_d;
         sym_q <= sym_d;
         bcnt_q <= bcnt_d;
         last_q <= last_d;
         lvl_q <= lvl_d;
         cell_q <= (!act_w || cell_end_w) ? 4'h0 : cell_q + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= 1'b0;
         gap_cnt_q <= '0;
         t1_q <= 1'b0;
         t2_q <= 1'b0;
         t3_q <= 1'b0;
      end else begin
         t1_q <= tach_pin;
         t2_q <= t1_q;
         t3_q <= t2_q;
         if (start_w) mode_q <= phase_encoded_mode;
         if (start_w) gap_cnt_q <= '0;
         else if ((wst_q == W_GAP) && tach_w && !gap_done_w) gap_cnt_q <= gap_cnt_q + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-track clock recovery
   track_bus_if tb ();
   rd_state_t rd_st_q;

   assign tb.rearm = (rd_st_q == R_HUNT);

   for (genvar g = 0; g < `NTRK; g++) begin : g_trk
      track_rx #(.IDX(g)) u_trk (
         .clk     (clk),
         .rst_n   (rst_n),
         .head_in (head_rd[g]),
         .tb      (tb.rx)
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // deskew, regeneration and output
   sym_t       buf_q [`NSLOT], buf_d [`NSLOT], have_q [`NSLOT], have_d [`NSLOT];
   logic [1:0] wp_q [`NTRK], wp_d [`NTRK];
   logic [1:0] rp_q;
   sym_t       armed_q, armed_d, fail_q, raw_w, fixed_w;
   logic       skew_d, pend_v_q, pend_fix_q, done_q;
   logic [7:0] pend_q;
   logic [7:0] ring_q [`RING_N];
   logic [2:0] wi_q, ci_q;

   wire reading_w  = (rd_st_q == R_DATA);
   wire complete_w = reading_w && (&(have_q[rp_q] | fail_q));
   wire zero_w     = (raw_w == `ZERO_SYM);
   wire end_w      = (complete_w && zero_w) || (reading_w && !(|tb.locked));
   wire emit_w     = complete_w && !zero_w && pend_v_q;
   wire [8:0] new_drop_w = reading_w ? (tb.drop & ~fail_q) : '0;
   wire multi_w    = (new_drop_w & (new_drop_w - 9'h001)) != '0;

   assign raw_w   = buf_q[rp_q] & ~fail_q;
   assign fixed_w = raw_w | (fail_q & {9{~^raw_w}});

   // slots fill per track at their own pace; clear before refill
   always_comb begin
      buf_d = buf_q;
      have_d = have_q;
      wp_d = wp_q;
      armed_d = armed_q;
      skew_d = 1'b0;
      if (!reading_w) begin
         buf_d = '{default: '0};
         have_d = '{default: '0};
         wp_d = '{default: '0};
         armed_d = '0;
      end else begin
         if (complete_w) have_d[rp_q] = '0;
         for (int i = 0; i < `NTRK; i++) begin
            if (tb.bit_valid[i] && !fail_q[i]) begin
               if (!armed_q[i]) begin
                  armed_d[i] = tb.bit_val[i];
               end else begin
                  if (have_d[wp_q[i]][i]) skew_d = 1'b1;
                  buf_d[wp_q[i]][i] = tb.bit_val[i];
                  have_d[wp_q[i]][i] = 1'b1;
                  wp_d[i] = wp_q[i] + 2'h1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_q <= '{default: '0};
         have_q <= '{default: '0};
         wp_q <= '{default: '0};
         armed_q <= '0;
         rp_q <= '0;
      end else begin
         buf_q <= buf_d;
         have_q <= have_d;
         wp_q <= wp_d;
         armed_q <= armed_d;
         rp_q <= !reading_w ? 2'h0 : (complete_w ? rp_q + 2'h1 : rp_q);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_st_q <= R_HUNT;
         fail_q <= '0;
         done_q <= 1'b0;
      end else begin
         if (!reading_w) fail_q <= '0;
         else if ((fail_q == '0) && !multi_w) fail_q <= new_drop_w;
         // trailing burst must not reopen a block: wait for the gap first
         if (end_w) done_q <= 1'b1;
         else if (!(|tb.locked)) done_q <= 1'b0;
         case (rd_st_q)
            R_HUNT: if (phase_encoded_mode && (&tb.locked) && !done_q) rd_st_q <= R_DATA;
            R_DATA: if (end_w) rd_st_q <= R_HUNT;
            default: rd_st_q <= R_HUNT;
         endcase
      end
   end

   // one-byte holdback drops the trailing burst mark at block end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_v_q <= 1'b0;
         pend_q <= '0;
         pend_fix_q <= 1'b0;
         rd_valid <= 1'b0;
         rd_byte <= '0;
         rd_fixed <= 1'b0;
         rd_sig_err <= 1'b0;
         rd_uncorr <= 1'b0;
         rd_block_end <= 1'b0;
         chk_err <= 1'b0;
      end else begin
         rd_valid <= emit_w;
         rd_sig_err <= (new_drop_w != '0);
         rd_uncorr <= skew_d || multi_w || ((new_drop_w != '0) && (fail_q != '0))
                      || (complete_w && !zero_w && (fail_q == '0) && !(^raw_w));
         rd_block_end <= end_w;
         chk_err <= emit_w && erase_on && (pend_q != ring_q[ci_q]);
         if (emit_w) begin
            rd_byte <= pend_q;
            rd_fixed <= pend_fix_q;
         end
         if (end_w || !reading_w) pend_v_q <= 1'b0;
         else if (complete_w) begin
            pend_v_q <= 1'b1;
            pend_q <= fixed_w[7:0];
            pend_fix_q <= (fail_q != '0);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ring_q <= '{default: '0};
         wi_q <= '0;
         ci_q <= '0;
      end else begin
         if (take_w) ring_q[wi_q] <= wr_data;
         if (start_w) wi_q <= '0;
         else if (take_w) wi_q <= wi_q + 3'h1;
         if (start_w) ci_q <= '0;
         else if (emit_w && erase_on) ci_q <= ci_q + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_erase_covers_write: assert property (write_gate |-> erase_on)
      else $error("write gate without erase");
   a_pe_mid_flip: assert property ((write_gate && mode_q && cell_q == `CELL_HALF)
      |=> head_wr == ~$past(head_wr))
      else $error("missing mid-cell reversal");
   a_pe_polarity: assert property ((write_gate && mode_q && cell_q == 4'h0)
      |=> (head_wr == ~sym_q) ##8 (head_wr == sym_q))
      else $error("wrong cell polarity");
   a_nrzi_ones_only: assert property ((write_gate && !mode_q && cell_q == 4'h0)
      |=> (head_wr ^ $past(head_wr)) == sym_q)
      else $error("transition-on-one mismatch");
   a_parity_odd: assert property (take_w |=> ^sym_q)
      else $error("even parity written");
   a_gap_length: assert property ($rose(write_gate) |-> gap_cnt_q == `GAP_TACH)
      else $error("short interblock gap");
   a_burst_wraps: assert property ((wst_q == W_DATA && cell_end_w && !take_w && mode_q)
      |=> sym_q == `MARK_SYM && wst_q == W_POST)
      else $error("no trailing burst");
   a_byte_complete: assert property (rd_valid |-> $past(complete_w && !zero_w))
      else $error("byte passed before nine bits");
   a_drop_flagged: assert property ((reading_w && (tb.drop & ~fail_q) != '0) |=> rd_sig_err)
      else $error("lost signal not flagged");
   a_fail_held: assert property ((reading_w && fail_q != '0 && !end_w)
      |=> fail_q == $past(fail_q))
      else $error("failed track released in block");

   c_block_read: cover property (rd_valid ##[1:400] rd_block_end);
   c_fixed_byte: cover property (rd_valid && rd_fixed);
   c_write_done: cover property (wst_q == W_POST ##1 wst_q == W_IDLE);
   c_readback_bad: cover property (chk_err);
endmodule : phase_encoded_tape_codec
`default_nettype wire

// ==== tb/tape_head_model.sv ====
/*
 * Tape head model: second-gap readback of the written flux with a fixed
 * skew per track, optional dropout of chosen tracks, and the capstan
 * tachometer, which pulses only while the tape moves (erase on).
 * Assumes head_wr and erase_on come from the codec on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module tape_head_model (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire tape_codec_pkg::sym_t head_wr,
   input  wire logic                 erase_on,
   input  wire logic [8:0]           drop_mask,
   output tape_codec_pkg::sym_t      head_rd,
   output logic                      tach_pin
);
   import tape_codec_pkg::*;

   sym_t       line_q [64];
   logic [2:0] tach_div_q;

   ////////////////////////////////////////////////////////////////////////
   // tachometer: one rising edge every 8 clocks while moving
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tach_div_q <= 3'h0;
         tach_pin   <= 1'b0;
      end else if (erase_on) begin
         tach_div_q <= tach_div_q + 3'h1;
         tach_pin   <= tach_div_q[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // readback gap: track t lags by 6+5t clocks, up to about three cells;
   // a dropped track freezes, so it shows no reversal at all
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 64; i++) begin
            line_q[i] <= '0;
         end
         head_rd <= '0;
      end else begin
         line_q[0] <= head_wr;
         for (int i = 1; i < 64; i++) begin
            line_q[i] <= line_q[i - 1];
         end
         for (int t = 0; t < 9; t++) begin
            if (!drop_mask[t]) begin
               head_rd[t] <= line_q[4 + 5 * t][t];
            end
         end
      end
   end
endmodule : tape_head_model
`default_nettype wire

// ==== tb/phase_encoded_tape_codec_tb.sv ====
/*
 * Self-checking bench for the tape codec: writes blocks in both modes,
 * checks the flux pattern, gap and erase timing, and the readback.
 * Assumes tape_head_model closes the loop from head_wr to head_rd.
 */
`timescale 1ns/1ps
`default_nettype none
module phase_encoded_tape_codec_tb;
   import tape_codec_pkg::*;

   logic       clk;
   logic       rst_n;
   logic       phase_encoded_mode;
   logic       wr_start;
   logic       wr_valid;
   logic [7:0] wr_data;
   logic       wr_last;
   logic       wr_ready;
   logic       tach_pin;
   sym_t       head_rd;
   sym_t       head_wr;
   logic       write_gate;
   logic       erase_on;
   logic       interblock_gap;
   logic       rd_valid;
   logic [7:0] rd_byte;
   logic       rd_fixed;
   logic       rd_sig_err;
   logic       rd_uncorr;
   logic       rd_block_end;
   logic       chk_err;
   logic [8:0] drop_mask;
   int         error_cnt;
   int         n_compared;
   int         fix_cnt;
   int         sig_cnt;
   int         unc_cnt;
   int         blk_cnt;
   int         chk_cnt;
   logic [7:0] rq [$];
   logic [7:0] data_tbl [6] = '{8'h00, 8'hff, 8'ha5, 8'h3c, 8'h01, 8'h80};

   phase_encoded_tape_codec dut (
      .clk(clk), .rst_n(rst_n), .phase_encoded_mode(phase_encoded_mode),
      .wr_start(wr_start), .wr_valid(wr_valid), .wr_data(wr_data),
      .wr_last(wr_last), .wr_ready(wr_ready), .tach_pin(tach_pin),
      .head_rd(head_rd), .head_wr(head_wr), .write_gate(write_gate),
      .erase_on(erase_on), .interblock_gap(interblock_gap),
      .rd_valid(rd_valid), .rd_byte(rd_byte), .rd_fixed(rd_fixed),
      .rd_sig_err(rd_sig_err), .rd_uncorr(rd_uncorr),
      .rd_block_end(rd_block_end), .chk_err(chk_err)
   );

   tape_head_model head (
      .clk(clk), .rst_n(rst_n), .head_wr(head_wr), .erase_on(erase_on),
      .drop_mask(drop_mask), .head_rd(head_rd), .tach_pin(tach_pin)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   // read side monitor: outputs stand one cycle, sampled mid-cycle
   always @(negedge clk) begin
      if (rd_valid === 1'b1) rq.push_back(rd_byte);
      if (rd_valid === 1'b1 && rd_fixed === 1'b1) fix_cnt++;
      if (rd_sig_err === 1'b1) sig_cnt++;
      if (rd_uncorr === 1'b1) unc_cnt++;
      if (rd_block_end === 1'b1) blk_cnt++;
      if (chk_err === 1'b1) chk_cnt++;
   end

   ////////////////////////////////////////////////////////////////////////
   // one block of six bytes: gap, bytes with flux checks, wait for close
   task automatic run_block(input logic pe, input logic [8:0] drop, input bit poke,
                            input bit need_end);
      int   n;
      sym_t s;
      sym_t prev;
      phase_encoded_mode = pe;
      rq.delete();
      fix_cnt = 0;
      sig_cnt = 0;
      unc_cnt = 0;
      blk_cnt = 0;
      chk_cnt = 0;
      @(posedge clk);
      #1 wr_start = 1'b1;
      @(posedge clk);
      #1 wr_start = 1'b0;
      check(erase_on, 1, "erase after start");
      check(interblock_gap, 1, "gap after start");
      n = 0;
      while (interblock_gap === 1'b1 && n < 2000) begin
         @(posedge clk);
         #1 n++;
      end
      check(n >= 470 && n <= 495, 1, "gap length");
      check(write_gate, 1, "gate after gap");
      for (int k = 0; k < 6; k++) begin
         s = {~^data_tbl[k], data_tbl[k]};
         wr_valid = 1'b1;
         wr_data = data_tbl[k];
         wr_last = (k == 5);
         n = 0;
         do begin
            @(negedge clk);
            n++;
         end while (wr_ready !== 1'b1 && n < 1000);
         check(wr_ready, 1, "byte taken");
         prev = head_wr;
         @(posedge clk);
         #1 wr_start = poke && k == 2;
         if (k == 3) drop_mask = drop;
         check(erase_on, 1, "erase during data");
         repeat (5) begin
            @(posedge clk);
            #1 wr_start = 1'b0;
         end
         if (pe) begin
            check(head_wr, sym_t'(~s), "first half cell");
            repeat (8) @(posedge clk);
            #1 check(head_wr, s, "second half cell");
         end else begin
            check(head_wr, prev ^ s, "toggle on ones");
         end
      end
      wr_valid = 1'b0;
      wr_last = 1'b0;
      n = 0;
      while (erase_on === 1'b1 && n < 3000) begin
         @(posedge clk);
         #1 n++;
      end
      check(write_gate, 0, "gate after block");
      n = 0;
      while (need_end && blk_cnt == 0 && n < 3000) begin
         @(posedge clk);
         #1 n++;
      end
      repeat (4) @(posedge clk);
      #1 drop_mask = 9'h000;
   endtask : run_block

   ////////////////////////////////////////////////////////////////////////
   task automatic t_pe_clean();
      run_block(1'b1, 9'h000, 1'b1, 1'b1);
      check(rq.size(), 6, "byte count");
      for (int k = 0; k < 6; k++) begin
         check(rq[k], data_tbl[k], "readback byte");
      end
      check(chk_cnt, 0, "readback compare");
      check(fix_cnt + sig_cnt + unc_cnt, 0, "clean flags");
      check(blk_cnt, 1, "block end");
      repeat (40) @(posedge clk);
      #1 check(erase_on, 0, "busy start ignored");
      $display("test pe_clean done");
   endtask : t_pe_clean

   task automatic t_pe_drop();
      run_block(1'b1, 9'h008, 1'b0, 1'b1);
      check(rq.size(), 6, "byte count");
      for (int k = 0; k < 6; k++) begin
         check(rq[k], data_tbl[k], "rebuilt byte");
      end
      check(fix_cnt > 0, 1, "fixed flag");
      check(sig_cnt, 1, "signal loss");
      check(unc_cnt, 0, "no uncorrectable");
      check(chk_cnt, 0, "readback compare");
      $display("test pe_drop done");
   endtask : t_pe_drop

   task automatic t_pe_two();
      run_block(1'b1, 9'h048, 1'b0, 1'b0);
      check(unc_cnt > 0, 1, "two tracks lost");
      check(sig_cnt, 2, "signal loss twice");
      $display("test pe_two done");
   endtask : t_pe_two

   task automatic t_nrzi();
      run_block(1'b0, 9'h000, 1'b0, 1'b0);
      check(rq.size(), 0, "no read in nrzi");
      $display("test nrzi done");
   endtask : t_nrzi

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      rst_n = 1'b0;
      phase_encoded_mode = 1'b1;
      wr_start = 1'b0;
      wr_valid = 1'b0;
      wr_data = 8'h00;
      wr_last = 1'b0;
      drop_mask = 9'h000;
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      t_pe_clean();
      t_pe_drop();
      t_pe_two();
      t_nrzi();
      end_of_test();
   end

   initial begin
      #600000;
      error_cnt++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule : phase_encoded_tape_codec_tb
`default_nettype wire
